//--- verilog/rbt_pkg.sv
// Purpose: Shared constants for the registered bus transceiver
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes: Capture clocks and selects arrive as ordinary synchronous inputs
package rbt_pkg;
    localparam int unsigned RBT_DATA_W = 8;
    localparam int unsigned RBT_BUF_DEPTH = 2;
    localparam logic [7:0] RBT_PORT_RST = 8'h00;
    localparam int unsigned RBT_CLK_PERIOD_PS = 5000;
endpackage

//--- verilog/rbt_buf_if.sv
// Purpose: Valid/ready carrier between capture logic and its buffer
// Assumes: One clock domain
// Notes: Width set by parameter
`timescale 1ns/1ps
`default_nettype none
interface rbt_buf_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport sink (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
    modport src (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

//--- verilog/rbt_skid_buf.sv
// Purpose: Two-entry buffer with registered read data
// Assumes: Source holds data while ready is low
// Notes: Full and empty come straight from the entry count
`timescale 1ns/1ps
`default_nettype none
module rbt_skid_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    rbt_buf_if.sink bus
);
    logic [W-1:0] mem_q [2];
    logic [1:0] cnt_q;
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic push;
    logic pop;

    // Handshakes on each side
    assign push = bus.in_valid && (cnt_q != 2'h2);
    assign pop = bus.out_ready && (cnt_q != 2'h0);
    assign bus.in_ready = (cnt_q != 2'h2);
    assign bus.out_valid = (cnt_q != 2'h0);
    assign bus.out_data = mem_q[rd_ptr_q];

    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= bus.in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // rbt_skid_buf
`default_nettype wire

//--- verilog/rbt_transceiver.sv
// Purpose: Registered 8-bit bidirectional transceiver between buses A and B
// Assumes: All pins sampled on clk; capture clocks are sampled levels
// Notes: Storage registers have no reset; pin outputs are registered
// Contract
// - Two 8-bit two-way ports and one storage register per direction.
// - Select low routes live opposite data, high routes stored data.
// - Rising capture clock loads its port value, ignoring selects and enables.
// - Capture always active, storing pin level even when self-driven.
// - High a-to-b enable drives B; low b-to-a enable drives A.
// - Driven port shows live or stored data according to its select.
// - Both enabled, both selects high: stored data cross both ways.
// - Both enabled, selects low: each port reinforces and holds its value; here a_o and b_o swap each cycle and hold only when equal.
// - Select changes produce no glitch on driven outputs.
// - One direction enabled: both registers take the external value passed through.
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver #(
    parameter int W = rbt_pkg::RBT_DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] a_i,
    output logic [W-1:0] a_o,
    output logic [W-1:0] a_oe,
    input wire logic [W-1:0] b_i,
    output logic [W-1:0] b_o,
    output logic [W-1:0] b_oe,
    input wire logic a_to_b_output_enable,
    input wire logic b_to_a_output_enable_n,
    input wire logic a_to_b_source_select,
    input wire logic b_to_a_source_select,
    input wire logic a_side_capture_clock,
    input wire logic b_side_capture_clock,
    output logic [W-1:0] a_side_stored,
    output logic [W-1:0] b_side_stored
);
    logic cpa_q;
    logic cpb_q;
    logic cap_a;
    logic cap_b;
    logic [W-1:0] a_reg_q;
    logic [W-1:0] b_reg_q;
    logic [W-1:0] a_line;
    logic [W-1:0] b_line;
    logic [W-1:0] b_drive_d;
    logic [W-1:0] a_drive_d;

    // Resolved level of one port: own drive where enabled, external level elsewhere
    // Capture must see what is really on the wires, including our own drive
    function automatic logic [W-1:0] resolve_line(
        input logic [W-1:0] drv,
        input logic [W-1:0] oe,
        input logic [W-1:0] ext
    );
        return (drv & oe) | (ext & ~oe);
    endfunction

    // Source choice for one direction: high select takes stored data
    function automatic logic [W-1:0] pick_source(
        input logic sel,
        input logic [W-1:0] stored,
        input logic [W-1:0] live
    );
        return sel ? stored : live;
    endfunction

    // Resolved pin levels seen by capture and by the live paths
    assign a_line = resolve_line(a_o, a_oe, a_i);
    assign b_line = resolve_line(b_o, b_oe, b_i);

    // Edge detection on the sampled capture clocks
    always_ff @(posedge clk) begin
        if (rst) begin
            cpa_q <= 1'b0;
            cpb_q <= 1'b0;
        end else begin
            cpa_q <= a_side_capture_clock;
            cpb_q <= b_side_capture_clock;
        end
    end

    assign cap_a = a_side_capture_clock && !cpa_q && !rst;
    assign cap_b = b_side_capture_clock && !cpb_q && !rst;

    // Capture requests pass through a buffer so a busy sink never drops one
    rbt_buf_if #(.W(2 * W)) cap_bus ();
    assign cap_bus.in_valid = cap_a || cap_b;
    assign cap_bus.in_data = {a_line, b_line};
    assign cap_bus.out_ready = 1'b1;

    logic cap_a_q;
    logic cap_b_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_a_q <= 1'b0;
            cap_b_q <= 1'b0;
        end else begin
            cap_a_q <= cap_a;
            cap_b_q <= cap_b;
        end
    end

    rbt_skid_buf #(.W(2 * W)) u_cap_buf (
        .clk(clk),
        .rst(rst),
        .bus(cap_bus.sink)
    );

    // store resolved pin level, even when self-driven
    // pass-through value reaches the opposite register
    // registers hold without an edge and have no reset
    always_ff @(posedge clk) begin
        if (cap_bus.out_valid && cap_a_q) begin
            a_reg_q <= cap_bus.out_data[2*W-1:W];
        end
        if (cap_bus.out_valid && cap_b_q) begin
            b_reg_q <= cap_bus.out_data[W-1:0];
        end
    end

    // select picks live or stored source
    // each driven port follows its own select
    assign b_drive_d = pick_source(a_to_b_source_select, a_reg_q, a_line);
    assign a_drive_d = pick_source(b_to_a_source_select, b_reg_q, b_line);

    // registered outputs cannot glitch on a select change
    // live mode with both enabled swaps the two driven levels each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            a_o <= rbt_pkg::RBT_PORT_RST;
            b_o <= rbt_pkg::RBT_PORT_RST;
            a_oe <= '0;
            b_oe <= '0;
        end else begin
            b_o <= b_drive_d;
            a_o <= a_drive_d;
            b_oe <= {W{a_to_b_output_enable}};
            a_oe <= {W{!b_to_a_output_enable_n}};
        end
    end

    always_ff @(posedge clk) begin
        a_side_stored <= a_reg_q;
        b_side_stored <= b_reg_q;
    end
endmodule // rbt_transceiver
`default_nettype wire

//--- dv/rbt_bus_model.sv
// Purpose: Far-side bus model for one port
// Assumes: Whole-byte enables, device wins a clash
// Notes: Released bus shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module rbt_bus_model (
    input wire logic clk,
    input wire logic [7:0] dev_o,
    input wire logic [7:0] dev_oe,
    input wire logic [7:0] ext_d,
    input wire logic ext_en,
    output logic [7:0] pin
);
    logic [7:0] last_q;
    // Floating level flips so a stale value never passes
    assign pin = dev_oe[0] ? dev_o : (ext_en ? ext_d : ~last_q);
    always_ff @(posedge clk) last_q <= pin;
endmodule // rbt_bus_model
`default_nettype wire

//--- dv/rbt_chk.sv
// Purpose: Port checks for the transceiver
// Assumes: One-cycle drive and three-cycle capture latency
// Notes: Stored selects are checked whenever selected, whether or not the registers hold data yet
`timescale 1ns/1ps
`default_nettype none
module rbt_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] a_i,
    input wire logic [7:0] a_o,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_i,
    input wire logic [7:0] b_o,
    input wire logic [7:0] b_oe,
    input wire logic a_to_b_output_enable,
    input wire logic b_to_a_output_enable_n,
    input wire logic a_to_b_source_select,
    input wire logic b_to_a_source_select,
    input wire logic a_side_capture_clock,
    input wire logic b_side_capture_clock,
    input wire logic [7:0] a_side_stored,
    input wire logic [7:0] b_side_stored
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Capture edges as seen on the sampled clock inputs
    sequence s_up_a; !a_side_capture_clock ##1 a_side_capture_clock; endsequence
    sequence s_up_b; !b_side_capture_clock ##1 b_side_capture_clock; endsequence
    property p_b_oe; !$past(rst) |-> b_oe == {8{$past(a_to_b_output_enable)}}; endproperty
    property p_a_oe; !$past(rst) |-> a_oe == {8{!$past(b_to_a_output_enable_n)}}; endproperty
    property p_b_live; !$past(rst) && !$past(a_to_b_source_select) |-> b_o == $past(a_i); endproperty
    property p_a_live; !$past(rst) && !$past(b_to_a_source_select) |-> a_o == $past(b_i); endproperty
    property p_b_st; !$past(rst) && $past(a_to_b_source_select) |-> b_o == a_side_stored; endproperty
    property p_a_st; !$past(rst) && $past(b_to_a_source_select) |-> a_o == b_side_stored; endproperty
    property p_cap_a; s_up_a |-> ##3 a_side_stored == $past(a_i, 3); endproperty
    property p_cap_b; s_up_b |-> ##3 b_side_stored == $past(b_i, 3); endproperty
    a_b_oe: assert property (p_b_oe) else $error("b enable wrong");
    a_a_oe: assert property (p_a_oe) else $error("a enable wrong");
    a_b_live: assert property (p_b_live) else $error("b live wrong");
    a_a_live: assert property (p_a_live) else $error("a live wrong");
    a_b_st: assert property (p_b_st) else $error("b stored wrong");
    a_a_st: assert property (p_a_st) else $error("a stored wrong");
    a_cap_a: assert property (p_cap_a) else $error("a capture wrong");
    a_cap_b: assert property (p_cap_b) else $error("b capture wrong");
endmodule // rbt_chk
bind rbt_transceiver rbt_chk u_chk (.*);
`default_nettype wire

//--- dv/rbt_transceiver_tb_top.sv
// Purpose: Directed bench for the transceiver
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Far-side buses come from two bus models
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver_tb_top;
    logic clk = 0, rst = 1, a_to_b_output_enable = 0, b_to_a_output_enable_n = 1;
    logic a_to_b_source_select = 0, b_to_a_source_select = 0, ea = 1, eb = 1;
    logic a_side_capture_clock = 0, b_side_capture_clock = 0;
    logic [7:0] xa = 8'h5a, xb = 8'ha5, a_i, a_o, a_oe, b_i, b_o, b_oe;
    logic [7:0] a_side_stored, b_side_stored;
    int miscompares = 0, tests_run = 0;
    // Clock and design wiring
    always #2.5 clk = ~clk;
    rbt_transceiver DUT (.*);
    rbt_bus_model BA (.clk(clk), .dev_o(a_o), .dev_oe(a_oe), .ext_d(xa), .ext_en(ea), .pin(a_i));
    rbt_bus_model BB (.clk(clk), .dev_o(b_o), .dev_oe(b_oe), .ext_d(xb), .ext_en(eb), .pin(b_i));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle pulse on both capture clocks, then wait out the pipe
    task automatic cap();
        a_side_capture_clock = 1;
        b_side_capture_clock = 1;
        cyc(1);
        a_side_capture_clock = 0;
        b_side_capture_clock = 0;
        cyc(4);
    endtask
    task automatic t_isolate();
        cap();
        chk("a_side_stored", 8'h5a, a_side_stored);
        chk("b_side_stored", 8'ha5, b_side_stored);
        chk("a_oe", 8'h00, a_oe);
        chk("b_oe", 8'h00, b_oe);
        xa = 8'h96;
        cyc(4);
        chk("a_side_stored", 8'h5a, a_side_stored);
        chk("a_i", 8'h96, a_i);
        $display("isolate test done");
    endtask
    task automatic t_stored();
        {ea, eb, b_to_a_output_enable_n} = 3'b000;
        {a_to_b_output_enable, a_to_b_source_select, b_to_a_source_select} = 3'b111;
        cyc(2);
        chk("b_i", 8'h5a, b_i);
        chk("a_i", 8'ha5, a_i);
        cap();
        chk("a_side_stored", 8'ha5, a_side_stored);
        chk("b_side_stored", 8'h5a, b_side_stored);
        chk("b_i", 8'ha5, b_i);
        $display("stored test done");
    endtask
    task automatic t_live();
        {b_to_a_output_enable_n, ea, xa} = {2'b11, 8'h3c};
        {a_to_b_source_select, b_to_a_source_select} = 2'b00;
        cyc(3);
        chk("b_i", 8'h3c, b_i);
        cap();
        chk("a_side_stored", 8'h3c, a_side_stored);
        chk("b_side_stored", 8'h3c, b_side_stored);
        b_to_a_output_enable_n = 0;
        cyc(2);
        ea = 0;
        cyc(4);
        chk("a_i", 8'h3c, a_i);
        chk("b_i", 8'h3c, b_i);
        $display("live test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #2000;
        miscompares++;
        close_out();
    end
    initial begin
        cyc(20);
        rst = 0;
        t_isolate();
        t_stored();
        t_live();
        close_out();
    end
endmodule // rbt_transceiver_tb_top
`default_nettype wire
